// ### logic/rcv_reset_cause_vmon.v
// Reset-cause bookkeeping, two supply detectors and the write-protect gate.
// Assumes a single 20 MHz clock, a plain register port, and analog comparator and
// reset-source pulses arriving asynchronously from outside.
// sys_reset is expected to be folded back into rst; cause flags, detector settings
// and the detector 0 start bit deliberately ignore rst so they outlive it.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/100ps
`include "rcv_defines.vh"
module rcv_reset_cause_vmon #(
    parameter SLOW_DIV = `RCV_T_SLOW_NS / `RCV_T_CLK_NS
) (
    input wire clk,
    input wire rst,
    input wire [9:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire por_n,
    input wire hw_reset_n,
    input wire wdt_reset,
    input wire osc_stop_reset,
    input wire det0_above,
    input wire det2_above,
    input wire [7:0] option_setting_word,
    output reg sys_reset,
    output reg irq,
    output reg [7:0] clock_mode_a,
    output reg [7:0] clock_mode_b,
    output reg [7:0] clock_mode_c,
    output reg [7:0] pll_control,
    output reg [7:0] peripheral_clock_ctrl,
    output reg [7:0] fast_osc_adjust_a,
    output reg [7:0] fast_osc_adjust_b,
    output reg [7:0] port9_direction,
    output reg [7:0] serial4_mode,
    output reg [7:0] drive_capacity,
    output reg [7:0] pin_assignment,
    output reg [7:0] processor_mode_ext,
    output reg [7:0] detector_edge_select,
    output reg [7:0] detector2_level_select,
    output reg [7:0] monitor0_control,
    output reg [7:0] monitor2_control
);

    // Address compare used by every decoded write; the read mux uses its own case
    function hit;
        input [9:0] a;
        input [9:0] b;
        begin
            hit = (a == b);
        end
    endfunction

    // Sticky status update: a new event beats a write-one clear in the same cycle,
    // so an event can never be lost to a clear that raced it
    function w1c;
        input cur;
        input set;
        input clr;
        begin
            w1c = set | (cur & ~clr);
        end
    endfunction

    // Register state; names follow the register map where software can see them
    reg [7:0] write_protect_ctrl;
    reg [7:0] voltage_detect_enable;
    reg [7:0] reset_cause_flags;
    reg [7:0] irq_status;
    reg [7:0] irq_mask;
    reg [1:0] por_sync, hw_sync, wdt_sync, osc_sync, d0_sync, d2_sync;
    reg [15:0] slow_cnt;
    reg slow_tick;
    reg d0_ok, d2_ok;
    reg d2_ok_q;
    reg det0_on;
    reg sw_req;
    reg [2:0] rst_hold;
    reg [7:0] opt_meta;
    reg [7:0] opt_sync;
    reg [7:0] next_rdata;
    wire wr_clk, wr_port, wr_vdet, wr_proc;
    wire vmon0_trip, vmon2_trip;
    wire en_wr;
    wire [1:0] stat_clr;

    // Two-flop synchronisers for all asynchronous pins.
    // Pins are taken active high at the first flop so later logic sees one polarity.
    always @(posedge clk) begin
        por_sync <= {por_sync[0], ~por_n};
        hw_sync <= {hw_sync[0], ~hw_reset_n};
        wdt_sync <= {wdt_sync[0], wdt_reset};
        osc_sync <= {osc_sync[0], osc_stop_reset};
        d0_sync <= {d0_sync[0], det0_above};
        d2_sync <= {d2_sync[0], det2_above};
    end

    // The option word comes from outside the clock domain too; it is static after
    // power-on, so a plain two-flop copy of all eight bits is safe
    always @(posedge clk) begin
        opt_meta <= option_setting_word;
        opt_sync <= opt_meta;
    end

    // Slow on-chip oscillator tick; comparators are only looked at on it.
    // Limitation: a comparator glitch shorter than one tick may be missed entirely.
    // The divider restarts with the core, so the first look after reset is a tick late.
    always @(posedge clk) begin
        if (rst) begin
            slow_cnt <= 16'h0000;
            slow_tick <= 1'b0;
        end else if (slow_cnt == SLOW_DIV[15:0] - 16'h0001) begin
            slow_cnt <= 16'h0000;
            slow_tick <= 1'b1;
        end else begin
            slow_cnt <= slow_cnt + 16'h0001;
            slow_tick <= 1'b0;
        end
    end

    // Sampled detector levels; a disabled detector reads as supply good.
    // d2_ok_q holds d2_ok from the previous clock so only a fall raises the interrupt.
    always @(posedge clk) begin
        if (rst) begin
            d0_ok <= 1'b1;
            d2_ok <= 1'b1;
            d2_ok_q <= 1'b1;
        end else begin
            if (slow_tick) begin
                d0_ok <= d0_sync[1] | ~det0_on;
                d2_ok <= d2_sync[1] | ~voltage_detect_enable[`RCV_V_DET2_EN];
            end
            d2_ok_q <= d2_ok;
        end
    end

    // Lower level trips reset only when monitor 0 asks for it, upper level only when monitor 2 asks for it
    // A disabled detector never trips, because its sampled level is forced good.
    assign vmon0_trip = ~d0_ok & monitor0_control[0];
    assign vmon2_trip = ~d2_ok & monitor2_control[0];

    // Write gates from the protect register. A blocked write is dropped silently,
    // so software that must be sure reads the register back.
    assign wr_clk = reg_wr & write_protect_ctrl[`RCV_P_CLOCK];
    assign wr_port = reg_wr & write_protect_ctrl[`RCV_P_PORT];
    assign wr_vdet = reg_wr & write_protect_ctrl[`RCV_P_VDET];
    assign wr_proc = reg_wr & write_protect_ctrl[`RCV_P_PROC];

    // Decodes pulled out of the process that uses each
    assign en_wr = wr_vdet & hit(reg_addr, `RCV_A_VENABLE);
    assign stat_clr = (reg_wr & hit(reg_addr, `RCV_A_IRQ_STAT)) ? reg_wdata[1:0] : 2'h0;

    // Reset generator: any source holds the system in reset for a few cycles.
    // The block's own rst is the chip reset and is driven by sys_reset outside.
    // The seven-cycle hold stretches a one-cycle software request into a clean reset;
    // power-on and the hardware pin keep sys_reset up for as long as they stay low.
    always @(posedge clk) begin
        if (por_sync[1] | hw_sync[1] | wdt_sync[1] | osc_sync[1] | sw_req
            | vmon0_trip | vmon2_trip) begin
            rst_hold <= 3'h7;
        end else if (rst_hold != 3'h0) begin
            rst_hold <= rst_hold - 3'h1;
        end
        sys_reset <= (rst_hold != 3'h0) | por_sync[1] | hw_sync[1];
    end

    // Cause flags live outside rst so they survive the reset they record.
    // Power-on clears them all and sets none; bits 0, 4 and 7 have no source.
    always @(posedge clk) begin
        if (por_sync[1]) begin
            reset_cause_flags <= `RCV_R_ZERO;
        end else begin
            if (hw_sync[1])
                reset_cause_flags[`RCV_C_HW] <= 1'b1;
            if (sw_req)
                reset_cause_flags[`RCV_C_SW] <= 1'b1;
            if (wdt_sync[1])
                reset_cause_flags[`RCV_C_WDT] <= 1'b1;
            if (vmon2_trip)
                reset_cause_flags[`RCV_C_VMON2] <= 1'b1;
            if (osc_sync[1])
                reset_cause_flags[`RCV_C_OSC] <= 1'b1;
        end
    end

    // Detector 0 start comes from the option word on power-on or hardware reset.
    // It sits apart from the enable register so the detector runs before software does.
    always @(posedge clk) begin
        if (por_sync[1] | hw_sync[1]) begin
            det0_on <= ~opt_sync[`RCV_O_DET0_OFF];
        end else if (en_wr) begin
            det0_on <= reg_wdata[`RCV_V_DET0_EN];
        end
    end

    // Protect, processor-mode and interrupt registers
    always @(posedge clk) begin
        if (rst) begin
            write_protect_ctrl <= `RCV_R_ZERO;
            processor_mode_ext <= `RCV_R_ZERO;
            irq_mask <= `RCV_R_ZERO;
            irq_status <= `RCV_R_ZERO;
            sw_req <= 1'b0;
            irq <= 1'b0;
        end else begin
            // The protect register and the software-reset port are never locked, so a
            // program that has gone astray can still restart the chip
            if (reg_wr & hit(reg_addr, `RCV_A_PROTECT))
                write_protect_ctrl <= reg_wdata & 8'h4d;
            if (wr_proc & hit(reg_addr, `RCV_A_PROC_EXT))
                processor_mode_ext <= reg_wdata;
            if (reg_wr & hit(reg_addr, `RCV_A_IRQ_MASK))
                irq_mask <= reg_wdata & 8'h03;
            sw_req <= reg_wr & hit(reg_addr, `RCV_A_SW_RESET) & reg_wdata[0];
            // Write-one clears, but a new event in the same cycle wins.
            // The monitor 0 bit is set by a trip that also resets the core, so while
            // rst is fed from sys_reset software will rarely find it still set.
            irq_status[`RCV_I_UPPER_DETECT_LEVEL] <= w1c(irq_status[`RCV_I_UPPER_DETECT_LEVEL], d2_ok_q & ~d2_ok,
                stat_clr[`RCV_I_UPPER_DETECT_LEVEL]);
            irq_status[`RCV_I_LOWER_DETECT_LEVEL] <= w1c(irq_status[`RCV_I_LOWER_DETECT_LEVEL], vmon0_trip,
                stat_clr[`RCV_I_LOWER_DETECT_LEVEL]);
            irq <= |(irq_status & irq_mask);
        end
    end

    // Clock-generator group; like the port group it returns to zero on every
    // system reset, the detector-caused ones included
    always @(posedge clk) begin
        if (rst) begin
            clock_mode_a <= `RCV_R_ZERO;
            clock_mode_b <= `RCV_R_ZERO;
            clock_mode_c <= `RCV_R_ZERO;
            pll_control <= `RCV_R_ZERO;
            peripheral_clock_ctrl <= `RCV_R_ZERO;
            fast_osc_adjust_a <= `RCV_R_ZERO;
            fast_osc_adjust_b <= `RCV_R_ZERO;
        end else if (wr_clk) begin
            if (hit(reg_addr, `RCV_A_CLK_A)) clock_mode_a <= reg_wdata;
            if (hit(reg_addr, `RCV_A_CLK_B)) clock_mode_b <= reg_wdata;
            if (hit(reg_addr, `RCV_A_CLK_C)) clock_mode_c <= reg_wdata;
            if (hit(reg_addr, `RCV_A_PLL)) pll_control <= reg_wdata;
            if (hit(reg_addr, `RCV_A_PERI_CLK)) peripheral_clock_ctrl <= reg_wdata;
            if (hit(reg_addr, `RCV_A_FOSC_A)) fast_osc_adjust_a <= reg_wdata;
            if (hit(reg_addr, `RCV_A_FOSC_B)) fast_osc_adjust_b <= reg_wdata;
        end
    end

    // Port group, guarded by protect bit 2.
    // A locked write here leaves the pins exactly as they were.
    always @(posedge clk) begin
        if (rst) begin
            port9_direction <= `RCV_R_ZERO;
            serial4_mode <= `RCV_R_ZERO;
            drive_capacity <= `RCV_R_ZERO;
            pin_assignment <= `RCV_R_ZERO;
        end else if (wr_port) begin
            if (hit(reg_addr, `RCV_A_PORT9_DIR)) port9_direction <= reg_wdata;
            if (hit(reg_addr, `RCV_A_SER4_MODE)) serial4_mode <= reg_wdata;
            if (hit(reg_addr, `RCV_A_DRIVE)) drive_capacity <= reg_wdata;
            if (hit(reg_addr, `RCV_A_PIN_ASSIGN)) pin_assignment <= reg_wdata;
        end
    end

    // Voltage-detector group; monitor settings must outlive detector-caused resets,
    // so they clear only on power-on
    always @(posedge clk) begin
        if (por_sync[1]) begin
            voltage_detect_enable <= `RCV_R_ZERO;
            detector_edge_select <= `RCV_R_ZERO;
            detector2_level_select <= `RCV_R_ZERO;
            monitor0_control <= `RCV_R_ZERO;
            monitor2_control <= `RCV_R_ZERO;
        end else if (wr_vdet) begin
            if (hit(reg_addr, `RCV_A_VENABLE))
                voltage_detect_enable <= reg_wdata & 8'h80;
            if (hit(reg_addr, `RCV_A_EDGE_SEL)) detector_edge_select <= reg_wdata;
            if (hit(reg_addr, `RCV_A_LVL_SEL)) detector2_level_select <= reg_wdata;
            if (hit(reg_addr, `RCV_A_MON0)) monitor0_control <= reg_wdata;
            if (hit(reg_addr, `RCV_A_MON2)) monitor2_control <= reg_wdata;
        end
    end

    // Read mux; unmapped addresses, reserved bits and unused cause bits read zero.
    // Status bit 3 shows d2_ok as last sampled, so after detector 2 is switched off
    // the one appears at the next tick rather than at once.
    always @* begin
        next_rdata = 8'h00;
        case (reg_addr)
            `RCV_A_PROTECT: next_rdata = write_protect_ctrl;
            `RCV_A_PROC_EXT: next_rdata = processor_mode_ext;
            `RCV_A_CAUSE: next_rdata = reset_cause_flags;
            `RCV_A_VSTATUS: next_rdata = {4'h0, d2_ok, 3'h0};
            `RCV_A_VENABLE: next_rdata = {voltage_detect_enable[7], 1'b0, det0_on, 5'h00};
            `RCV_A_EDGE_SEL: next_rdata = detector_edge_select;
            `RCV_A_LVL_SEL: next_rdata = detector2_level_select;
            `RCV_A_MON0: next_rdata = monitor0_control;
            `RCV_A_MON2: next_rdata = monitor2_control;
            `RCV_A_CLK_A: next_rdata = clock_mode_a;
            `RCV_A_CLK_B: next_rdata = clock_mode_b;
            `RCV_A_CLK_C: next_rdata = clock_mode_c;
            `RCV_A_PLL: next_rdata = pll_control;
            `RCV_A_PERI_CLK: next_rdata = peripheral_clock_ctrl;
            `RCV_A_FOSC_A: next_rdata = fast_osc_adjust_a;
            `RCV_A_FOSC_B: next_rdata = fast_osc_adjust_b;
            `RCV_A_PORT9_DIR: next_rdata = port9_direction;
            `RCV_A_SER4_MODE: next_rdata = serial4_mode;
            `RCV_A_DRIVE: next_rdata = drive_capacity;
            `RCV_A_PIN_ASSIGN: next_rdata = pin_assignment;
            `RCV_A_IRQ_STAT: next_rdata = irq_status;
            `RCV_A_IRQ_MASK: next_rdata = irq_mask;
            default: next_rdata = 8'h00;
        endcase
    end

    // Read data stands only in the cycle after the strobe; zero elsewhere keeps a
    // stale value from being taken for a fresh answer
    always @(posedge clk) begin
        if (rst)
            reg_rdata <= 8'h00;
        else if (reg_rd)
            reg_rdata <= next_rdata;
        else
            reg_rdata <= 8'h00;
    end

endmodule // rcv_reset_cause_vmon

// ### logic/rcv_defines.vh
// Register offsets, field positions, reset values and timing for the reset-cause,
// voltage-detector and write-protect block. Definitions only.
`ifndef RCV_DEFINES_VH
`define RCV_DEFINES_VH
// Register offsets
`define RCV_A_PROTECT 10'h00a
`define RCV_A_PROC_EXT 10'h010
`define RCV_A_PERI_CLK 10'h012
`define RCV_A_CAUSE 10'h018
`define RCV_A_VSTATUS 10'h019
`define RCV_A_VENABLE 10'h01a
`define RCV_A_PLL 10'h01c
`define RCV_A_FOSC_A 10'h022
`define RCV_A_FOSC_B 10'h024
`define RCV_A_EDGE_SEL 10'h026
`define RCV_A_LVL_SEL 10'h028
`define RCV_A_MON0 10'h02a
`define RCV_A_MON2 10'h02c
`define RCV_A_CLK_A 10'h006
`define RCV_A_CLK_B 10'h007
`define RCV_A_CLK_C 10'h00c
`define RCV_A_PORT9_DIR 10'h0f3
`define RCV_A_SER4_MODE 10'h2a8
`define RCV_A_DRIVE 10'h2fe
`define RCV_A_PIN_ASSIGN 10'h370
`define RCV_A_IRQ_STAT 10'h030
`define RCV_A_IRQ_MASK 10'h031
`define RCV_A_SW_RESET 10'h032
// Protect bit positions
`define RCV_P_CLOCK 0
`define RCV_P_PORT 2
`define RCV_P_VDET 3
`define RCV_P_PROC 6
// Reset-cause bit positions
`define RCV_C_HW 1
`define RCV_C_SW 2
`define RCV_C_WDT 3
`define RCV_C_VMON2 5
`define RCV_C_OSC 6
// Voltage register bit positions
`define RCV_V_MON2 3
`define RCV_V_DET0_EN 5
`define RCV_V_DET2_EN 7
// Option word bit: zero starts detector 0 after power-on or hardware reset
`define RCV_O_DET0_OFF 6
// Interrupt status bits
`define RCV_I_UPPER_DETECT_LEVEL 0
`define RCV_I_LOWER_DETECT_LEVEL 1
// Reset values
`define RCV_R_ZERO 8'h00
`define RCV_R_VSTAT 8'h08
// Slow oscillator clock, about 125 kHz: sampling tick period in ns
`define RCV_T_SLOW_NS 8000
`define RCV_T_CLK_NS 50
`endif

// ### sim/rcv_reset_cause_vmon_chk.sv
// Checker for the reset-cause, detector and protect block.
// Sees only the top ports; mirrors the protect bits from bus writes.
`timescale 1ns/100ps
module rcv_reset_cause_vmon_chk (
    input wire clk,
    input wire rst,
    input wire [9:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire hw_reset_n,
    input wire wdt_reset,
    input wire sys_reset,
    input wire [7:0] clock_mode_a,
    input wire [7:0] pll_control,
    input wire [7:0] port9_direction,
    input wire [7:0] serial4_mode,
    input wire [7:0] monitor2_control,
    input wire [7:0] processor_mode_ext
);
    reg [7:0] prot;
    // Shadow of the protect bits; only bits 0, 2, 3 and 6 exist
    always @(posedge clk) begin
        if (rst)
            prot <= 8'h00;
        else if (reg_wr && reg_addr == 10'h00a)
            prot <= reg_wdata & 8'h4d;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // Locked writes leave the register alone, open ones land next edge
    property p_clk_shut;
        reg_wr && reg_addr == 10'h006 && !prot[0] |=> $stable(clock_mode_a);
    endproperty
    a_clk_shut: assert property (p_clk_shut) else $error("clock mode a written while locked");
    property p_clk_open;
        reg_wr && reg_addr == 10'h006 && prot[0] |=> clock_mode_a == $past(reg_wdata);
    endproperty
    a_clk_open: assert property (p_clk_open) else $error("clock mode a write lost");
    property p_pll_shut;
        reg_wr && reg_addr == 10'h01c && !prot[0] |=> $stable(pll_control);
    endproperty
    a_pll_shut: assert property (p_pll_shut) else $error("pll control written while locked");
    property p_port_open;
        reg_wr && reg_addr == 10'h0f3 && prot[2] |=> port9_direction == $past(reg_wdata);
    endproperty
    a_port_open: assert property (p_port_open) else $error("port 9 direction write lost");
    property p_ser_shut;
        reg_wr && reg_addr == 10'h2a8 && !prot[2] |=> $stable(serial4_mode);
    endproperty
    a_ser_shut: assert property (p_ser_shut) else $error("serial 4 mode written while locked");
    property p_mon2_shut;
        reg_wr && reg_addr == 10'h02c && !prot[3] |=> $stable(monitor2_control);
    endproperty
    a_mon2_shut: assert property (p_mon2_shut) else $error("monitor 2 written while locked");
    property p_proc_open;
        reg_wr && reg_addr == 10'h010 && prot[6] |=> processor_mode_ext == $past(reg_wdata);
    endproperty
    a_proc_open: assert property (p_proc_open) else $error("proc ext write lost");
    // Reset sources must reach the system reset within a few cycles
    property p_wdt_rst;
        $rose(wdt_reset) |-> ##[1:6] sys_reset;
    endproperty
    a_wdt_rst: assert property (p_wdt_rst) else $error("watchdog reset not raised");
    property p_hw_rst;
        $fell(hw_reset_n) |-> ##[1:6] sys_reset;
    endproperty
    a_hw_rst: assert property (p_hw_rst) else $error("hardware reset not raised");
    // Read data stands one cycle only
    property p_rd_once;
        reg_rd ##1 !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    a_rd_once: assert property (p_rd_once) else $error("read data held too long");
endmodule // rcv_reset_cause_vmon_chk

bind rcv_reset_cause_vmon rcv_reset_cause_vmon_chk i_rcv_reset_cause_vmon_chk (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hw_reset_n(hw_reset_n), .wdt_reset(wdt_reset),
    .sys_reset(sys_reset), .clock_mode_a(clock_mode_a), .pll_control(pll_control),
    .port9_direction(port9_direction), .serial4_mode(serial4_mode),
    .monitor2_control(monitor2_control), .processor_mode_ext(processor_mode_ext));

// ### sim/rcv_reset_cause_vmon_tb.sv
// Self-checking bench for the reset-cause, detector and protect block.
// Assumes sys_reset is folded back into rst, as on chip; sampling divider shortened to 4.
`timescale 1ns/100ps
module rcv_reset_cause_vmon_tb;
    reg clk = 0, rst_tb = 1, reg_wr = 0, reg_rd = 0, por_n = 0, hw_n = 1;
    reg wdt = 0, osc = 0, d0 = 1, d2 = 1;
    reg [9:0] addr = 10'h000;
    reg [7:0] wdata = 8'h00, opt = 8'h00;
    wire rst, sys_reset, irq;
    wire [7:0] rdata;
    wire [7:0] o [0:15];
    integer mismatches = 0, check_count = 0;
    localparam [159:0] TA = {10'h010, 10'h02c, 10'h02a, 10'h028, 10'h026, 10'h370, 10'h2fe,
        10'h2a8, 10'h0f3, 10'h024, 10'h022, 10'h012, 10'h01c, 10'h00c, 10'h007, 10'h006};
    // Every internal source resets the core, so flags must survive rst
    assign rst = rst_tb | sys_reset;
    initial forever #25 clk = ~clk;
    rcv_reset_cause_vmon #(.SLOW_DIV(4)) i_rcv_reset_cause_vmon (.clk(clk), .rst(rst),
        .reg_addr(addr), .reg_wdata(wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
        .por_n(por_n), .hw_reset_n(hw_n), .wdt_reset(wdt), .osc_stop_reset(osc),
        .det0_above(d0), .det2_above(d2), .option_setting_word(opt), .sys_reset(sys_reset),
        .irq(irq), .clock_mode_a(o[0]), .clock_mode_b(o[1]), .clock_mode_c(o[2]),
        .pll_control(o[3]), .peripheral_clock_ctrl(o[4]), .fast_osc_adjust_a(o[5]),
        .fast_osc_adjust_b(o[6]), .port9_direction(o[7]), .serial4_mode(o[8]),
        .drive_capacity(o[9]), .pin_assignment(o[10]), .detector_edge_select(o[11]),
        .detector2_level_select(o[12]), .monitor0_control(o[13]), .monitor2_control(o[14]),
        .processor_mode_ext(o[15]));
    task results;
        begin
            $display("checks %0d mismatches %0d", check_count, mismatches);
            if (mismatches == 0 && check_count > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    task chk(input [63:0] nm, input [7:0] e, input [7:0] g);
        begin
            check_count = check_count + 1;
            if (g !== e) begin
                mismatches = mismatches + 1;
                $display("[ERR] %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    // Bus cycles start one edge in, so back-to-back calls never double-drive a strobe
    task wr(input [9:0] a, input [7:0] d);
        begin
            @(posedge clk);
            addr <= a;
            wdata <= d;
            reg_wr <= 1'b1;
            @(posedge clk);
            reg_wr <= 1'b0;
        end
    endtask
    task rd(input [9:0] a, input [7:0] m, input [7:0] e);
        begin
            @(posedge clk);
            addr <= a;
            reg_rd <= 1'b1;
            @(posedge clk);
            reg_rd <= 1'b0;
            @(posedge clk) chk("rdata", e, rdata & m);
        end
    endtask
    // Bounded wait for sys_reset to reach a level; a hang ends the run
    task wres(input up);
        integer n;
        begin
            n = 0;
            while (sys_reset !== up && n < 400) begin
                @(posedge clk);
                n = n + 1;
            end
            if (sys_reset !== up) begin
                mismatches = mismatches + 1;
                $display("[ERR] sys_reset expected %b seen %b", up, sys_reset);
                results;
            end
        end
    endtask
    task settle;
        begin
            repeat (3) @(posedge clk);
            wres(1'b0);
            repeat (2) @(posedge clk);
        end
    endtask
    // Each locked group: closed write ignored, open write lands, relocked write ignored
    task t_prot;
        integer k, b;
        begin
            for (k = 0; k < 16; k = k + 1) begin
                b = k < 7 ? 0 : k < 11 ? 2 : k < 15 ? 3 : 6;
                wr(TA[k*10 +: 10], 8'h56);
                @(posedge clk) chk("locked", 8'h00, o[k]);
                wr(10'h00a, 8'h01 << b);
                wr(TA[k*10 +: 10], {k[3:0], 4'h2});
                wr(10'h00a, 8'h00);
                wr(TA[k*10 +: 10], 8'hff);
                @(posedge clk) chk("opened", {k[3:0], 4'h2}, o[k]);
            end
            wr(10'h00a, 8'hff);
            rd(10'h00a, 8'hff, 8'h4d);
            wr(10'h00a, 8'h00);
        end
    endtask
    // Each source sets its own sticky flag; flags outlive the resets that follow
    task t_cause;
        begin
            rd(10'h018, 8'hff, 8'h00);
            hw_n <= 1'b0;
            repeat (4) @(posedge clk);
            hw_n <= 1'b1;
            settle;
            rd(10'h018, 8'hff, 8'h02);
            rd(10'h01a, 8'h20, 8'h20);
            wdt <= 1'b1;
            repeat (3) @(posedge clk);
            wdt <= 1'b0;
            settle;
            rd(10'h018, 8'hff, 8'h0a);
            wr(10'h032, 8'h01);
            settle;
            rd(10'h018, 8'hff, 8'h0e);
            osc <= 1'b1;
            repeat (3) @(posedge clk);
            osc <= 1'b0;
            settle;
            rd(10'h018, 8'hff, 8'h4e);
            wr(10'h00a, 8'h08);
            wr(10'h01a, 8'he0);
            wr(10'h02c, 8'h01);
            wr(10'h00a, 8'h00);
            rd(10'h01a, 8'hff, 8'ha0);
            d2 <= 1'b0;
            wres(1'b1);
            d2 <= 1'b1;
            settle;
            rd(10'h018, 8'hff, 8'h6e);
        end
    endtask
    // Detector 2 drives the status flag and the masked interrupt
    task t_vdet;
        begin
            wr(10'h00a, 8'h08);
            wr(10'h02c, 8'h00);
            wr(10'h00a, 8'h00);
            d2 <= 1'b0;
            repeat (20) @(posedge clk);
            rd(10'h019, 8'h08, 8'h00);
            chk("irq_mask", 8'h00, {7'h00, irq});
            wr(10'h031, 8'h01);
            @(posedge clk);
            @(posedge clk) chk("irq_on", 8'h01, {7'h00, irq});
            d2 <= 1'b1;
            repeat (20) @(posedge clk);
            wr(10'h030, 8'h01);
            @(posedge clk);
            @(posedge clk) chk("irq_off", 8'h00, {7'h00, irq});
            wr(10'h00a, 8'h08);
            wr(10'h01a, 8'h20);
            wr(10'h02a, 8'h01);
            wr(10'h00a, 8'h00);
            d2 <= 1'b0;
            repeat (20) @(posedge clk);
            rd(10'h019, 8'h08, 8'h08);
            d2 <= 1'b1;
            d0 <= 1'b0;
            wres(1'b1);
            d0 <= 1'b1;
            settle;
            rd(10'h018, 8'hff, 8'h6e);
            opt <= 8'h40;
            hw_n <= 1'b0;
            repeat (4) @(posedge clk);
            hw_n <= 1'b1;
            settle;
            rd(10'h01a, 8'h20, 8'h00);
        end
    endtask
    // Power-on and core reset together, then the scenarios
    initial begin
        repeat (5) @(posedge clk);
        por_n <= 1'b1;
        rst_tb <= 1'b0;
        settle;
        t_prot;
        t_cause;
        t_vdet;
        results;
    end
endmodule // rcv_reset_cause_vmon_tb
